// *** verilog/ccgt_top.sv ***
// What this block does
// - select line high: internal 10 MHz reference is the time base
// - select line low: internal path and rear driver off, external path selected
// - rear panel reference output driven only with internal reference selected
// - selected reference forwarded as 10 MHz clock to microwave converter
// - selected reference divided by 100 in two decade stages to 100 kHz
// - accurate stable measurement gate supplied to the count chain
// - gate length selectable in decades from 100 us to 1 s
// - select codes 1 to 5 give ratios ten to hundred thousand
// - gate flop advances only on 100 kHz clock, others only enable it
// - no gate active: arm clear and divider free-running
// - arm set clears count enable and divider; sequencer then waits for arm clear
// - after arm clear, next 100 kHz clock sets count enable
// - following clock opens gate and divider starts counting
// - divider output goes high at half the selected count
// - full count: output falls, arm set, count enable cleared, close primed
// - next 100 kHz clock after terminal count closes the gate
`timescale 1ns/1ns
`default_nettype none
`include "ccgt_consts.svh"

module ccgt_top
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic REF_SEL,
    input wire logic INT_REF_IN,
    input wire logic EXT_REF_IN,
    input wire logic [`CCGT_SEL_W-1:0] GATE_SEL,
    input wire logic ARM_SET,
    input wire logic ARM_CLR,
    output logic INT_PATH_EN,
    output logic EXT_PATH_EN,
    output logic REAR_REF_OUT,
    output logic CONV_CLK_OUT,
    output logic GATE_CLK_OUT,
    output logic GATE_OUT,
    output logic GATE_ARMED,
    output logic COUNT_EN,
    output logic DIV_OUT
);

    // ----------------------------------------------------------------------
    // reference selection
    // ----------------------------------------------------------------------
    logic sel_ref;
    logic ref_q_reg;
    logic ref_edge;
    logic int_en_reg;
    logic ext_en_reg;
    logic rear_reg;
    logic conv_reg;

    assign sel_ref = REF_SEL ? INT_REF_IN : EXT_REF_IN;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            int_en_reg <= 1'b0;
            ext_en_reg <= 1'b0;
        end
        else
        begin
            int_en_reg <= REF_SEL;
            ext_en_reg <= !REF_SEL;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            rear_reg <= 1'b0;
        else
            rear_reg <= REF_SEL && INT_REF_IN;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            conv_reg <= 1'b0;
            ref_q_reg <= 1'b0;
        end
        else
        begin
            conv_reg <= sel_ref;
            ref_q_reg <= sel_ref;
        end
    end

    assign ref_edge = sel_ref && !ref_q_reg;

    // ----------------------------------------------------------------------
    // divide by 100 prescaler
    // ----------------------------------------------------------------------
    logic [`CCGT_DECADE_W-1:0] lo_count;
    logic [`CCGT_DECADE_W-1:0] hi_count;
    logic lo_carry;
    logic hi_carry;
    logic tick_reg;
    logic gclk_reg;

    ccgt_decade u_decade_lo
    (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .step(ref_edge),
        .count_reg(lo_count),
        .carry(lo_carry)
    );

    ccgt_decade u_decade_hi
    (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .step(lo_carry),
        .count_reg(hi_count),
        .carry(hi_carry)
    );

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tick_reg <= 1'b0;
            gclk_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= hi_carry;
            gclk_reg <= (hi_count < `CCGT_DECADE_HALF);
        end
    end

    // ----------------------------------------------------------------------
    // gate ratio
    // ----------------------------------------------------------------------
    logic [`CCGT_DIV_W-1:0] ratio;
    logic [`CCGT_DIV_W-1:0] ratio_reg;

    always_comb
    begin
        case (GATE_SEL)
            `CCGT_SEL_100US: ratio = `CCGT_RATIO_1E1;
            `CCGT_SEL_1MS: ratio = `CCGT_RATIO_1E2;
            `CCGT_SEL_10MS: ratio = `CCGT_RATIO_1E3;
            `CCGT_SEL_100MS: ratio = `CCGT_RATIO_1E4;
            `CCGT_SEL_1S: ratio = `CCGT_RATIO_1E5;
            default: ratio = `CCGT_RATIO_1E1;
        endcase
    end

    // ----------------------------------------------------------------------
    // gate sequencer
    // ----------------------------------------------------------------------
    ccgt_pkg::ccgt_state_t state_reg;
    logic arm_reg;
    logic cnt_en_reg;
    logic gate_reg;
    logic [`CCGT_DIV_W-1:0] div_reg;
    logic half_reg;
    logic terminal;

    assign terminal = tick_reg && (state_reg == ccgt_pkg::CCGT_OPEN) && (div_reg == ratio_reg - `CCGT_DIV_ONE);

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            ratio_reg <= `CCGT_RATIO_1E1;
        else if (ARM_SET || state_reg == ccgt_pkg::CCGT_IDLE)
            ratio_reg <= ratio;
    end

    // arm: set by strobe or terminal count, set wins over clear
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            arm_reg <= 1'b0;
        else if (ARM_SET || terminal)
            arm_reg <= 1'b1;
        else if (ARM_CLR)
            arm_reg <= 1'b0;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            state_reg <= ccgt_pkg::CCGT_IDLE;
        else if (ARM_SET)
            state_reg <= ccgt_pkg::CCGT_ARMED;
        else
        begin
            case (state_reg)
                ccgt_pkg::CCGT_IDLE: state_reg <= ccgt_pkg::CCGT_IDLE;
                ccgt_pkg::CCGT_ARMED:
                    if (ARM_CLR)
                        state_reg <= ccgt_pkg::CCGT_RELEASED;
                ccgt_pkg::CCGT_RELEASED:
                    if (tick_reg)
                        state_reg <= ccgt_pkg::CCGT_ENABLED;
                ccgt_pkg::CCGT_ENABLED:
                    if (tick_reg)
                        state_reg <= ccgt_pkg::CCGT_OPEN;
                ccgt_pkg::CCGT_OPEN:
                    if (terminal)
                        state_reg <= ccgt_pkg::CCGT_DONE;
                ccgt_pkg::CCGT_DONE:
                    if (tick_reg)
                        state_reg <= arm_reg && !ARM_CLR ? ccgt_pkg::CCGT_CLOSED
                                                         : ccgt_pkg::CCGT_IDLE;
                ccgt_pkg::CCGT_CLOSED:
                    if (ARM_CLR)
                        state_reg <= ccgt_pkg::CCGT_IDLE;
                default: state_reg <= ccgt_pkg::CCGT_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            cnt_en_reg <= 1'b0;
        else if (ARM_SET || terminal)
            cnt_en_reg <= 1'b0;
        else if (tick_reg && state_reg == ccgt_pkg::CCGT_RELEASED)
            cnt_en_reg <= 1'b1;
    end

    // gate flop only moves on the 100 kHz tick
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            gate_reg <= 1'b0;
        else if (tick_reg)
        begin
            if (state_reg == ccgt_pkg::CCGT_ENABLED && cnt_en_reg)
                gate_reg <= 1'b1;
            else if (state_reg != ccgt_pkg::CCGT_OPEN)
                gate_reg <= 1'b0;
        end
    end

    // divider: free-run when idle, cleared by arm, counts while open
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            div_reg <= `CCGT_DIV_ZERO;
        else if (ARM_SET || terminal)
            div_reg <= `CCGT_DIV_ZERO;
        else if (tick_reg && state_reg == ccgt_pkg::CCGT_IDLE)
            div_reg <= (div_reg >= ratio_reg - `CCGT_DIV_ONE) ? `CCGT_DIV_ZERO
                                                              : div_reg + `CCGT_DIV_ONE;
        // opening tick is the first counted gate tick
        else if (tick_reg && (state_reg == ccgt_pkg::CCGT_OPEN || state_reg == ccgt_pkg::CCGT_ENABLED))
            div_reg <= div_reg + `CCGT_DIV_ONE;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            half_reg <= 1'b0;
        else if (terminal || ARM_SET)
            half_reg <= 1'b0;
        else
            half_reg <= (div_reg >= (ratio_reg >> 1));
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign INT_PATH_EN = int_en_reg;
    assign EXT_PATH_EN = ext_en_reg;
    assign REAR_REF_OUT = rear_reg;
    assign CONV_CLK_OUT = conv_reg;
    assign GATE_CLK_OUT = gclk_reg;
    assign GATE_OUT = gate_reg;
    assign GATE_ARMED = arm_reg;
    assign COUNT_EN = cnt_en_reg;
    assign DIV_OUT = half_reg;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    logic [7:0] edge_gap_reg;
    logic [`CCGT_DIV_W-1:0] open_ticks_reg;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            edge_gap_reg <= 8'h00;
        else if (hi_carry)
            edge_gap_reg <= 8'h00;
        else if (ref_edge)
            edge_gap_reg <= edge_gap_reg + 8'h01;
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            open_ticks_reg <= `CCGT_DIV_ZERO;
        else if (!gate_reg)
            open_ticks_reg <= `CCGT_DIV_ZERO;
        else if (tick_reg)
            open_ticks_reg <= open_ticks_reg + `CCGT_DIV_ONE;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    property p_int_sel;
        REF_SEL |=> INT_PATH_EN && !EXT_PATH_EN;
    endproperty
    a_int_sel: assert property (p_int_sel) else $error("internal path not enabled");

    property p_ext_sel;
        !REF_SEL |=> !INT_PATH_EN && EXT_PATH_EN && !REAR_REF_OUT;
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("external select not honoured");

    property p_rear_int_only;
        REAR_REF_OUT |-> $past(REF_SEL) && $past(INT_REF_IN);
    endproperty
    a_rear_int_only: assert property (p_rear_int_only) else $error("rear output without internal ref");

    property p_conv_fwd;
        (REF_SEL && EXT_REF_IN != INT_REF_IN) |=> CONV_CLK_OUT == $past(INT_REF_IN);
    endproperty
    a_conv_fwd: assert property (p_conv_fwd) else $error("converter clock not from selected ref");

    property p_prescale;
        hi_carry |-> edge_gap_reg == `CCGT_GAP_LAST;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler ratio not 100");

    property p_arm_set;
        ARM_SET |=> GATE_ARMED && !COUNT_EN && div_reg == `CCGT_DIV_ZERO;
    endproperty
    a_arm_set: assert property (p_arm_set) else $error("arm set did not clear enable and divider");

    property p_en_after_release;
        (tick_reg && state_reg == ccgt_pkg::CCGT_RELEASED && !ARM_SET) |=> COUNT_EN;
    endproperty
    a_en_after_release: assert property (p_en_after_release) else $error("count enable not set");

    property p_open_on_tick;
        $rose(GATE_OUT) |-> $past(tick_reg) && $past(COUNT_EN);
    endproperty
    a_open_on_tick: assert property (p_open_on_tick) else $error("gate opened off tick");

    property p_terminal;
        terminal && !ARM_SET |=> GATE_ARMED && !COUNT_EN && GATE_OUT && !DIV_OUT;
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal count effects missing");

    property p_gate_len;
        $fell(GATE_OUT) |-> open_ticks_reg == ratio_reg;
    endproperty
    a_gate_len: assert property (p_gate_len) else $error("gate length differs from ratio");

    property p_close;
        (state_reg == ccgt_pkg::CCGT_DONE && tick_reg) |=> !GATE_OUT;
    endproperty
    a_close: assert property (p_close) else $error("gate not closed after terminal");

    property p_idle_closed;
        state_reg == ccgt_pkg::CCGT_IDLE |-> !GATE_OUT;
    endproperty
    a_idle_closed: assert property (p_idle_closed) else $error("gate open while idle");

    property p_half;
        (state_reg == ccgt_pkg::CCGT_OPEN && div_reg >= (ratio_reg >> 1) && !terminal && !ARM_SET) |=> DIV_OUT;
    endproperty
    a_half: assert property (p_half) else $error("divider half output missing");

    c_gate_done: cover property ($fell(GATE_OUT));
    c_ext_ref: cover property (!REF_SEL ##1 CONV_CLK_OUT);
    c_rearm: cover property (state_reg == ccgt_pkg::CCGT_CLOSED ##1 state_reg == ccgt_pkg::CCGT_IDLE);

endmodule
`default_nettype wire

// *** verilog/ccgt_consts.svh ***
`ifndef CCGT_CONSTS_SVH
`define CCGT_CONSTS_SVH

// ----------------------------------------------------------------------
// reference and prescaler
// ----------------------------------------------------------------------
`define CCGT_REF_HZ 10000000
`define CCGT_GATE_CLK_HZ 100000
`define CCGT_PRESCALE (`CCGT_REF_HZ / `CCGT_GATE_CLK_HZ)
`define CCGT_DECADE_W 4
`define CCGT_DECADE_ZERO 4'h0
`define CCGT_DECADE_LAST 4'h9
`define CCGT_DECADE_HALF 4'h5
`define CCGT_GAP_LAST 8'h63

// ----------------------------------------------------------------------
// gate select codes and divide ratios
// ----------------------------------------------------------------------
`define CCGT_SEL_W 3
`define CCGT_SEL_100US 3'h1
`define CCGT_SEL_1MS 3'h2
`define CCGT_SEL_10MS 3'h3
`define CCGT_SEL_100MS 3'h4
`define CCGT_SEL_1S 3'h5
`define CCGT_DIV_W 17
`define CCGT_DIV_ZERO 17'h00000
`define CCGT_DIV_ONE 17'h00001
`define CCGT_RATIO_1E1 17'h0000a
`define CCGT_RATIO_1E2 17'h00064
`define CCGT_RATIO_1E3 17'h003e8
`define CCGT_RATIO_1E4 17'h02710
`define CCGT_RATIO_1E5 17'h186a0

`endif

// *** verilog/ccgt_pkg.sv ***
`default_nettype none

package ccgt_pkg;

    // gate sequence, gray along the usual path from idle up to closed
    typedef enum logic [2:0] {
        CCGT_IDLE = 3'h0,
        CCGT_ARMED = 3'h1,
        CCGT_RELEASED = 3'h3,
        CCGT_ENABLED = 3'h2,
        CCGT_OPEN = 3'h6,
        CCGT_DONE = 3'h7,
        CCGT_CLOSED = 3'h5
    } ccgt_state_t;

endpackage

`default_nettype wire

// *** verilog/ccgt_decade.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ccgt_consts.svh"

module ccgt_decade
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic step,
    output logic [`CCGT_DECADE_W-1:0] count_reg,
    output logic carry
);

    // ----------------------------------------------------------------------
    // one decade stage, carry while stepping from nine
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            count_reg <= `CCGT_DECADE_ZERO;
        else if (step)
            count_reg <= (count_reg == `CCGT_DECADE_LAST) ? `CCGT_DECADE_ZERO
                                                          : count_reg + 4'h1;
    end

    assign carry = step && (count_reg == `CCGT_DECADE_LAST);

endmodule
`default_nettype wire

// *** verification/ccgt_proc_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module ccgt_proc_model
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic start,
    input wire logic slow,
    input wire logic gate_out,
    output logic arm_set,
    output logic arm_clr,
    output logic busy
);
    localparam int MAX_WAIT = 30000;

    initial
    begin
        int n;
        arm_set = 1'b0;
        arm_clr = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge CLK);
            if (ARST_N === 1'b1 && start === 1'b1)
            begin
                #1;
                busy = 1'b1;
                arm_set = 1'b1;
                @(posedge CLK);
                #1;
                arm_set = 1'b0;
                repeat (slow ? 37 : 1) @(posedge CLK);
                #1;
                arm_clr = 1'b1;
                @(posedge CLK);
                #1;
                arm_clr = 1'b0;
                n = 0;
                while (gate_out !== 1'b1 && n < MAX_WAIT)
                begin
                    @(posedge CLK);
                    n++;
                end
                while (gate_out !== 1'b0 && n < MAX_WAIT)
                begin
                    @(posedge CLK);
                    n++;
                end
                repeat (slow ? 53 : 2) @(posedge CLK);
                #1;
                arm_clr = 1'b1;
                @(posedge CLK);
                #1;
                arm_clr = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/ccgt_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ccgt_consts.svh"

module ccgt_tb;
    localparam int TICK = 200;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ref_sel = 1'b1;
    logic int_ref = 1'b0;
    logic ext_ref = 1'b0;
    logic [`CCGT_SEL_W-1:0] gate_sel = `CCGT_SEL_100US;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic run = 1'b0;
    logic arm_set, arm_clr, busy;
    logic int_en, ext_en, rear, conv, gclk, gate, armed, cen, div;
    logic p_ce = 1'b0, p_go = 1'b0, p_gc = 1'b0, gc_in = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0, ce_rise = 0, ce_fall = 0, gc_rise = 0, open_at = 0, want = 0;
    int exp_q[$];

    always #4 clk = ~clk;

    ccgt_top uut (.CLK(clk), .ARST_N(arst_n), .REF_SEL(ref_sel), .INT_REF_IN(int_ref), .EXT_REF_IN(ext_ref),
        .GATE_SEL(gate_sel), .ARM_SET(arm_set), .ARM_CLR(arm_clr), .INT_PATH_EN(int_en), .EXT_PATH_EN(ext_en),
        .REAR_REF_OUT(rear), .CONV_CLK_OUT(conv), .GATE_CLK_OUT(gclk), .GATE_OUT(gate), .GATE_ARMED(armed),
        .COUNT_EN(cen), .DIV_OUT(div));

    ccgt_proc_model proc (.CLK(clk), .ARST_N(arst_n), .start(start), .slow(slow), .gate_out(gate),
        .arm_set(arm_set), .arm_clr(arm_clr), .busy(busy));

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_len(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp)
        begin
            n_errors++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // reference drive: selected toggles, unselected is noise
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        #1;
        if (run)
        begin
            int_ref = ref_sel ? ~int_ref : 1'($urandom);
            ext_ref = ref_sel ? 1'($urandom) : ~ext_ref;
        end
    end

    // ----------------------------------------------------------------
    // strobe responses
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (arm_set === 1'b1)
        begin
            #2;
            chk_bit("armed_after_set", 1'b1, armed);
            chk_bit("cen_after_set", 1'b0, cen);
            chk_bit("div_after_set", 1'b0, div);
        end
        else if (arm_clr === 1'b1)
        begin
            #2;
            chk_bit("armed_after_clr", 1'b0, armed);
        end
    end

    // ----------------------------------------------------------------
    // gate monitor, takes the oldest expected length
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        #2;
        cyc++;
        if (cen === 1'b1 && p_ce === 1'b0)
            ce_rise = cyc;
        if (cen === 1'b0 && p_ce === 1'b1)
            ce_fall = cyc;
        if (gclk === 1'b1 && p_gc === 1'b0)
        begin
            if (gate === 1'b1 && gc_in)
                chk_len("gate_clk_period", TICK, cyc - gc_rise);
            gc_rise = cyc;
            gc_in = (gate === 1'b1);
        end
        if (gate === 1'b1 && p_go === 1'b0)
        begin
            open_at = cyc;
            want = (exp_q.size() > 0) ? exp_q[0] : 0;
            chk_len("enable_to_open", TICK, cyc - ce_rise);
            chk_bit("armed_at_open", 1'b0, armed);
        end
        if (gate === 1'b1 && cyc - open_at == want / 4)
            chk_bit("div_first_half", 1'b0, div);
        if (gate === 1'b1 && cyc - open_at == (want * 3) / 4)
            chk_bit("div_second_half", 1'b1, div);
        if (gate === 1'b0 && p_go === 1'b1)
        begin
            chk_len("gate_length", want, cyc - open_at);
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
            chk_len("terminal_to_close", TICK, cyc - ce_fall);
            chk_bit("armed_at_close", 1'b1, armed);
            chk_bit("div_at_close", 1'b0, div);
        end
        p_ce = cen;
        p_go = gate;
        p_gc = gclk;
    end

    task automatic gate_run(input logic sel, input logic [`CCGT_SEL_W-1:0] code, input int ratio, input logic slw);
        int n;
        @(posedge clk);
        #1;
        run = 1'b1;
        ref_sel = sel;
        gate_sel = code;
        slow = slw;
        repeat (3 * TICK) @(posedge clk);
        #1;
        exp_q.push_back(ratio * TICK);
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        repeat (3) @(posedge clk);
        n = 0;
        while (busy === 1'b1 && n < ratio * TICK + 4000)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    initial
    begin
        repeat (80000) @(posedge clk);
        n_errors++;
        $display("FAIL watchdog expected done seen hang");
        tally_and_finish();
    end

    initial
    begin
        int seed, n;
        logic p_sel, p_int, p_ext, seen, pd;
        seed = $urandom(32'hc88e0a67);
        p_sel = 1'b1;
        p_int = 1'b0;
        p_ext = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        for (int i = 0; i < 80; i++)
        begin
            @(posedge clk);
            #1;
            if (i > 0)
            begin
                chk_bit("int_path_en", p_sel, int_en);
                chk_bit("ext_path_en", ~p_sel, ext_en);
                chk_bit("rear_ref", p_sel & p_int, rear);
                chk_bit("conv_clk", p_sel ? p_int : p_ext, conv);
                chk_bit("idle_gate", 1'b0, gate);
                chk_bit("idle_armed", 1'b0, armed);
            end
            p_sel = 1'($urandom);
            p_int = 1'($urandom);
            p_ext = 1'($urandom);
            ref_sel = p_sel;
            int_ref = p_int;
            ext_ref = p_ext;
            gate_sel = 3'($urandom);
        end
        gate_run(1'b1, `CCGT_SEL_100US, 10, 1'b0);
        gate_run(1'b0, 3'h0, 10, 1'b1);
        gate_run(1'b1, `CCGT_SEL_1MS, 100, 1'b0);
        gate_run(1'b0, 3'h7, 10, 1'b0);
        @(posedge clk);
        #1;
        gate_sel = `CCGT_SEL_100US;
        n = 0;
        seen = 1'b0;
        pd = div;
        repeat (20 * TICK)
        begin
            @(posedge clk);
            #1;
            if (div !== pd)
                n++;
            pd = div;
            if (gate !== 1'b0)
                seen = 1'b1;
        end
        chk_bit("div_free_runs", 1'b1, n >= 2);
        chk_bit("gate_stays_closed", 1'b0, seen);
        chk_len("pending_gates", 0, exp_q.size());
        tally_and_finish();
    end
endmodule

`default_nettype wire
